// [src/lsg_map.svh]
// Notes on behaviour
// [RL1] Limits during homing feed the homing sequence
// [RL2] Limits outside homing mean overtravel stop
// [RL3] Overtravel detection enable bit, default enabled
// [RL4] Overtravel stop: immediate (0) or deceleration (1)
// [RL5] Limit contacts normally open (0) or closed (1)
// [RL6] Home sensor used only in three-sensor mode
// [RL7] Home sensor normally open (0) or closed (1)
// [RL8] Slit sensor normally open (0) or closed (1)
// [RL9] Home detection optionally qualified by slit sensor
// [RL10] Sixteen general signals relay pins and network bits
// [RL11] Network bit drives direct output on or off
// [RL12] Direct input reported as network output bit
// [RL13] Per-input logic inversion before relaying
// [RL14] Resolution 1000*B/A must lie in 100..10000
// [RL15] Gear A and B accept 1..65535, default 1
// [RL16] Out-of-range resolution raises gear warning
// [RL17] Configure or power-up with warning raises alarm
// [RL18] Master re-mechanical_origin_sensor or presets after resolution change
// [RL19] Master keeps gears multiples of 50 for pulse
// [RL20] Shaft-angle pulse fifty times per output revolution
// [RL21] All pins synchronised before any decision
`ifndef LSG_MAP_SVH
`define LSG_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LSG_OFS_CTRL      8'h00
`define LSG_OFS_GEAR_A    8'h04
`define LSG_OFS_GEAR_B    8'h08
`define LSG_OFS_GP_DIR    8'h0c
`define LSG_OFS_GP_INV    8'h10
`define LSG_OFS_NET_IN    8'h14
`define LSG_OFS_NET_OUT   8'h18
`define LSG_OFS_STATUS    8'h1c
`define LSG_OFS_COMMAND   8'h20

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define LSG_CTRL_OT_EN      0
`define LSG_CTRL_OT_DECEL   1
`define LSG_CTRL_LS_NC      2
`define LSG_CTRL_ORIGIN_NC  3
`define LSG_CTRL_SLIT_NC    4
`define LSG_CTRL_SLIT_QUAL  5
`define LSG_CTRL_MODE_LO    6
`define LSG_CTRL_MODE_HI    7
`define LSG_CTRL_WIDTH      8
`define LSG_CTRL_RESET      8'h01

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define LSG_ST_OT_PLUS      0
`define LSG_ST_OT_MINUS     1
`define LSG_ST_GEAR_WARN    2
`define LSG_ST_GEAR_ALARM   3
`define LSG_ST_PLUS_ACT     4
`define LSG_ST_MINUS_ACT    5
`define LSG_ST_ORIGIN_ACT   6
`define LSG_ST_SLIT_ACT     7
`define LSG_ST_WIDTH        8

// ----------------------------------------------------------------
// Command register bits
// ----------------------------------------------------------------
`define LSG_CMD_CONFIGURE   0
`define LSG_CMD_CLR_OT      1
`define LSG_CMD_CLR_ALARM   2

// ----------------------------------------------------------------
// Gear and resolution constants
// ----------------------------------------------------------------
`define LSG_GEAR_RESET      16'h0001
`define LSG_RES_SCALE       1000
`define LSG_RES_MIN         100
`define LSG_RES_MAX         10000
`define LSG_PULSES_PER_REV  50

`endif

// [src/lsg_pkg.sv]
package lsg_pkg;

  typedef enum logic [1:0] {
    HOME_TWO_SENSOR,
    HOME_THREE_SENSOR,
    HOME_ONE_WAY,
    HOME_PUSH
  } home_mode_e;

  typedef logic [15:0] gear_t;

endpackage

// [src/in_sync.sv]
`timescale 1ns/1ps
module in_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // Only the second stage is visible; the first stage feeds nothing else.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// [src/limit_sensor_gear.sv]
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "lsg_map.svh"
module limit_sensor_gear
  import lsg_pkg::*;
#(
  parameter int NUM_GP = 16
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PLUS_LIMIT_SENSOR,
  input wire logic MINUS_LIMIT_SENSOR,
  input wire logic MECHANICAL_ORIGIN_SENSOR,
  input wire logic SLIT_SENSOR,
  input wire logic [NUM_GP-1:0] DIRECT_IN,
  output logic [NUM_GP-1:0] DIRECT_OUT,
  input wire logic HOMING_ACTIVE,
  input wire logic STEP_PULSE,
  output logic HOMING_PLUS_LIMIT,
  output logic HOMING_MINUS_LIMIT,
  output logic HOME_FOUND,
  output logic STOP_IMMEDIATE,
  output logic STOP_DECEL,
  output logic GEAR_WARNING,
  output logic GEAR_ALARM,
  output logic SHAFT_ANGLE_PULSE_OUT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int SYNC_W = NUM_GP + 4;

  logic [SYNC_W-1:0] pins_sync;
  logic [`LSG_CTRL_WIDTH-1:0] ctrl_q;
  gear_t gear_a_q;
  gear_t gear_b_q;
  logic [NUM_GP-1:0] gp_dir_q;
  logic [NUM_GP-1:0] gp_inv_q;
  logic [NUM_GP-1:0] net_in_q;
  logic [NUM_GP-1:0] net_out_q;
  logic [NUM_GP-1:0] direct_out_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic setup;
  logic access;
  logic wr_en;
  logic addr_hit;
  logic [2:0] cmd;
  logic plus_act;
  logic minus_act;
  logic origin_act;
  logic slit_act;
  logic [NUM_GP-1:0] gp_in_act;
  home_mode_e home_mode;
  logic ot_plus_q;
  logic ot_minus_q;
  logic gear_warn;
  logic gear_alarm_q;
  logic [29:0] scaled_a;
  logic [29:0] scaled_b;
  logic [29:0] scaled_max;
  logic [21:0] tim_acc_q;
  logic [22:0] tim_sum;
  logic [22:0] tim_span;
  logic tim_q;
  logic homing_plus_q;
  logic homing_minus_q;
  logic home_found_q;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  in_sync #(
    .WIDTH(SYNC_W)
  ) pin_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .ce(CE),
    .d({DIRECT_IN, SLIT_SENSOR, MECHANICAL_ORIGIN_SENSOR, MINUS_LIMIT_SENSOR, PLUS_LIMIT_SENSOR}),
    .q(pins_sync)
  ); // RL21

  // A normally closed contact opens on detection, so its level is inverted.
  assign plus_act = pins_sync[0] ^ ctrl_q[`LSG_CTRL_LS_NC]; // RL5
  assign minus_act = pins_sync[1] ^ ctrl_q[`LSG_CTRL_LS_NC]; // RL5
  assign origin_act = pins_sync[2] ^ ctrl_q[`LSG_CTRL_ORIGIN_NC]; // RL7
  assign slit_act = pins_sync[3] ^ ctrl_q[`LSG_CTRL_SLIT_NC]; // RL8
  assign gp_in_act = pins_sync[SYNC_W-1:4] ^ gp_inv_q; // RL13
  assign home_mode = home_mode_e'(ctrl_q[`LSG_CTRL_MODE_HI:`LSG_CTRL_MODE_LO]);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // The slave answers with no wait state; a low clock enable stretches the access.
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && CE;
  assign wr_en = access && PWRITE && addr_hit;
  assign PREADY = CE;
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;
  assign cmd = wr_en && (PADDR == `LSG_OFS_COMMAND) ? PWDATA[2:0] : 3'h0;

  always_comb
  begin
    case (PADDR)
      `LSG_OFS_CTRL, `LSG_OFS_GEAR_A, `LSG_OFS_GEAR_B, `LSG_OFS_GP_DIR, `LSG_OFS_GP_INV,
      `LSG_OFS_NET_IN, `LSG_OFS_NET_OUT, `LSG_OFS_STATUS, `LSG_OFS_COMMAND: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so that PRDATA comes from a flop.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else if (CE && setup)
    begin
      pslverr_q <= !addr_hit;
      case (PADDR)
        `LSG_OFS_CTRL: prdata_q <= {24'h0, ctrl_q};
        `LSG_OFS_GEAR_A: prdata_q <= {16'h0, gear_a_q};
        `LSG_OFS_GEAR_B: prdata_q <= {16'h0, gear_b_q};
        `LSG_OFS_GP_DIR: prdata_q <= 32'(gp_dir_q);
        `LSG_OFS_GP_INV: prdata_q <= 32'(gp_inv_q);
        `LSG_OFS_NET_IN: prdata_q <= 32'(net_in_q);
        `LSG_OFS_NET_OUT: prdata_q <= 32'(net_out_q);
        `LSG_OFS_STATUS: prdata_q <= {24'h0, slit_act, origin_act, minus_act, plus_act,
                                      gear_alarm_q, gear_warn, ot_minus_q, ot_plus_q};
        default: prdata_q <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl_q <= `LSG_CTRL_RESET; // RL3 RL4 RL5 RL7 RL8
      gp_dir_q <= '0;
      gp_inv_q <= '0;
      net_in_q <= '0;
    end
    else if (wr_en)
    begin
      case (PADDR)
        `LSG_OFS_CTRL: ctrl_q <= PWDATA[`LSG_CTRL_WIDTH-1:0];
        `LSG_OFS_GP_DIR: gp_dir_q <= PWDATA[NUM_GP-1:0];
        `LSG_OFS_GP_INV: gp_inv_q <= PWDATA[NUM_GP-1:0];
        `LSG_OFS_NET_IN: net_in_q <= PWDATA[NUM_GP-1:0];
        default: ;
      endcase
    end
  end

  // A gear value of zero lies outside the accepted range and is ignored.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      gear_a_q <= `LSG_GEAR_RESET; // RL15
      gear_b_q <= `LSG_GEAR_RESET; // RL15
    end
    else if (wr_en && PWDATA[15:0] != 16'h0)
    begin
      if (PADDR == `LSG_OFS_GEAR_A)
        gear_a_q <= PWDATA[15:0]; // RL15
      if (PADDR == `LSG_OFS_GEAR_B)
        gear_b_q <= PWDATA[15:0]; // RL15
    end
  end

  // ----------------------------------------------------------------
  // Overtravel and homing
  // ----------------------------------------------------------------
  // Overtravel flags stay set until cleared; a new detection beats a clear.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ot_plus_q <= 1'b0;
      ot_minus_q <= 1'b0;
    end
    else if (CE)
    begin
      if (!HOMING_ACTIVE && ctrl_q[`LSG_CTRL_OT_EN] && plus_act)
        ot_plus_q <= 1'b1; // RL2 RL3
      else if (cmd[`LSG_CMD_CLR_OT])
        ot_plus_q <= 1'b0;
      if (!HOMING_ACTIVE && ctrl_q[`LSG_CTRL_OT_EN] && minus_act)
        ot_minus_q <= 1'b1; // RL2 RL3
      else if (cmd[`LSG_CMD_CLR_OT])
        ot_minus_q <= 1'b0;
    end
  end

  assign STOP_IMMEDIATE = (ot_plus_q || ot_minus_q) && !ctrl_q[`LSG_CTRL_OT_DECEL]; // RL4
  assign STOP_DECEL = (ot_plus_q || ot_minus_q) && ctrl_q[`LSG_CTRL_OT_DECEL]; // RL4

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      homing_plus_q <= 1'b0;
      homing_minus_q <= 1'b0;
      home_found_q <= 1'b0;
    end
    else if (CE)
    begin
      homing_plus_q <= HOMING_ACTIVE && plus_act; // RL1
      homing_minus_q <= HOMING_ACTIVE && minus_act; // RL1
      home_found_q <= HOMING_ACTIVE && home_mode == HOME_THREE_SENSOR && origin_act
                      && (!ctrl_q[`LSG_CTRL_SLIT_QUAL] || slit_act); // RL6 RL9
    end
  end

  assign HOMING_PLUS_LIMIT = homing_plus_q;
  assign HOMING_MINUS_LIMIT = homing_minus_q;
  assign HOME_FOUND = home_found_q;

  // ----------------------------------------------------------------
  // General signal relay
  // ----------------------------------------------------------------
  // Signal i links DIRECT_IN[i] or DIRECT_OUT[i] with network bit i.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      direct_out_q <= '0;
      net_out_q <= '0;
    end
    else if (CE)
    begin
      direct_out_q <= net_in_q & gp_dir_q; // RL10 RL11
      net_out_q <= gp_in_act & ~gp_dir_q; // RL10 RL12
    end
  end

  assign DIRECT_OUT = direct_out_q;

  // ----------------------------------------------------------------
  // Gear check
  // ----------------------------------------------------------------
  // 100 <= 1000*B/A <= 10000 is tested by cross-multiplying, with no divider.
  // The upper bound needs 30 bits, since a full-scale A times the maximum would overflow 29.
  assign scaled_a = 30'(gear_a_q) * 30'(`LSG_RES_MIN);
  assign scaled_b = 30'(gear_b_q) * 30'(`LSG_RES_SCALE);
  assign scaled_max = 30'(gear_a_q) * 30'(`LSG_RES_MAX);
  assign gear_warn = (scaled_b < scaled_a) || (scaled_b > scaled_max); // RL14 RL16
  assign GEAR_WARNING = gear_warn;
  assign GEAR_ALARM = gear_alarm_q;

  // Gear values return to valid defaults at power-up, so only configure escalates here.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      gear_alarm_q <= 1'b0;
    else if (CE)
    begin
      if (cmd[`LSG_CMD_CONFIGURE] && gear_warn)
        gear_alarm_q <= 1'b1; // RL17
      else if (cmd[`LSG_CMD_CLR_ALARM] && !gear_warn)
        gear_alarm_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shaft-angle pulse
  // ----------------------------------------------------------------
  // Each step is A/(1000*B) revolution; one pulse per 1/50 revolution means
  // every 20*B/A steps, tracked exactly by adding A and wrapping at 20*B.
  assign tim_span = 23'(gear_b_q) * 23'(`LSG_RES_SCALE / `LSG_PULSES_PER_REV);
  assign tim_sum = 23'(tim_acc_q) + 23'(gear_a_q);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tim_acc_q <= 22'h0;
      tim_q <= 1'b0;
    end
    else if (CE)
    begin
      tim_q <= 1'b0;
      if (STEP_PULSE)
      begin
        if (tim_sum >= tim_span)
        begin
          tim_acc_q <= 22'(tim_sum - tim_span); // RL20
          tim_q <= 1'b1; // RL20
        end
        else
          tim_acc_q <= tim_sum[21:0];
      end
    end
  end

  assign SHAFT_ANGLE_PULSE_OUT = tim_q;

endmodule

// [verif/limit_sensor_gear_properties.sv]
`timescale 1ns/1ps
module limit_sensor_gear_properties #(
  parameter int NUM_GP = 16
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic PSLVERR,
  input wire logic HOMING_ACTIVE,
  input wire logic STEP_PULSE,
  input wire logic HOMING_PLUS_LIMIT,
  input wire logic HOME_FOUND,
  input wire logic STOP_IMMEDIATE,
  input wire logic STOP_DECEL,
  input wire logic GEAR_WARNING,
  input wire logic GEAR_ALARM,
  input wire logic SHAFT_ANGLE_PULSE_OUT,
  input wire logic [NUM_GP-1:0] DIRECT_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // Registered outputs move one edge after a write, so they need two quiet cycles.
  sequence quiet_s;
    !(PSEL && PENABLE && PWRITE);
  endsequence
  stop_exclusive_a: assert property (STOP_IMMEDIATE |-> !STOP_DECEL) else $error("both stops");
  ot_outside_homing_a: assert property ($rose(STOP_IMMEDIATE || STOP_DECEL) |-> !$past(HOMING_ACTIVE))
    else $error("overtravel while homing");
  homing_limit_a: assert property (HOMING_PLUS_LIMIT |-> $past(HOMING_ACTIVE)) else $error("limit");
  home_needs_homing_a: assert property (HOME_FOUND |-> $past(HOMING_ACTIVE)) else $error("home");
  alarm_needs_warn_a: assert property ($rose(GEAR_ALARM) |-> $past(GEAR_WARNING) && $past(PWRITE))
    else $error("alarm");
  warn_holds_a: assert property (quiet_s |=> $stable(GEAR_WARNING)) else $error("warn moved");
  pulse_after_step_a: assert property (SHAFT_ANGLE_PULSE_OUT |-> $past(STEP_PULSE)) else $error("pulse");
  out_holds_a: assert property (quiet_s ##1 quiet_s |=> $stable(DIRECT_OUT)) else $error("out moved");
  unmapped_err_a: assert property (PSEL && PENABLE && PADDR > 8'h20 |-> PSLVERR) else $error("no err");
endmodule

bind limit_sensor_gear limit_sensor_gear_properties #(.NUM_GP(NUM_GP)) chk_i (.CLK(CLK), .RESET_N(RESET_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PSLVERR(PSLVERR),
  .HOMING_ACTIVE(HOMING_ACTIVE), .STEP_PULSE(STEP_PULSE), .HOMING_PLUS_LIMIT(HOMING_PLUS_LIMIT),
  .HOME_FOUND(HOME_FOUND), .STOP_IMMEDIATE(STOP_IMMEDIATE), .STOP_DECEL(STOP_DECEL),
  .GEAR_WARNING(GEAR_WARNING), .GEAR_ALARM(GEAR_ALARM), .SHAFT_ANGLE_PULSE_OUT(SHAFT_ANGLE_PULSE_OUT),
  .DIRECT_OUT(DIRECT_OUT));

// [verif/sensor_model.sv]
`timescale 1ns/1ps
module sensor_model (
  input wire logic plus_act,
  input wire logic minus_act,
  input wire logic origin_act,
  input wire logic slit_act,
  input wire logic ls_nc,
  input wire logic origin_nc,
  input wire logic slit_nc,
  output logic plus_pin,
  output logic minus_pin,
  output logic origin_pin,
  output logic slit_pin
);
  // A closed-contact sensor breaks its circuit on detection, so its pin drops.
  assign plus_pin = plus_act ^ ls_nc;
  assign minus_pin = minus_act ^ ls_nc;
  assign origin_pin = origin_act ^ origin_nc;
  assign slit_pin = slit_act ^ slit_nc;
endmodule

// [verif/limit_sensor_gear_tb.sv]
`timescale 1ns/1ps
`include "lsg_map.svh"
module limit_sensor_gear_tb;
  logic clk, reset_n, ce, psel, penable, pwrite, homing, step, pready, pslverr, er;
  logic [7:0] paddr, ctrl, v;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] din, dout, dir, inv, ni;
  logic hp, hm, found, stop_i, stop_d, warn, alarm, tim, p_pin, m_pin, o_pin, s_pin;
  logic p_act, m_act, o_act, s_act;
  int mismatches, checked, cycles, pulses;
  int ga[6] = '{10, 11, 1, 1, 10, 65535};
  int gb[6] = '{12, 1, 10, 11, 1, 65535};

  limit_sensor_gear dut (.CLK(clk), .RESET_N(reset_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PLUS_LIMIT_SENSOR(p_pin), .MINUS_LIMIT_SENSOR(m_pin), .MECHANICAL_ORIGIN_SENSOR(o_pin),
    .SLIT_SENSOR(s_pin), .DIRECT_IN(din), .DIRECT_OUT(dout), .HOMING_ACTIVE(homing), .STEP_PULSE(step),
    .HOMING_PLUS_LIMIT(hp), .HOMING_MINUS_LIMIT(hm), .HOME_FOUND(found), .STOP_IMMEDIATE(stop_i),
    .STOP_DECEL(stop_d), .GEAR_WARNING(warn), .GEAR_ALARM(alarm), .SHAFT_ANGLE_PULSE_OUT(tim));
  sensor_model sm (.plus_act(p_act), .minus_act(m_act), .origin_act(o_act), .slit_act(s_act),
    .ls_nc(ctrl[2]), .origin_nc(ctrl[3]), .slit_nc(ctrl[4]), .plus_pin(p_pin), .minus_pin(m_pin),
    .origin_pin(o_pin), .slit_pin(s_pin));

  // ----------------------------------------
  // Clock, timeout and bus tasks
  // ----------------------------------------
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    pulses += (tim === 1'b1);
    if (cycles == 5000)
    begin
      mismatches++;
      final_report();
    end
  end
  task final_report;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (w && a == `LSG_OFS_CTRL) ctrl <= d[7:0];
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task steps(input int n);
    repeat (n)
    begin
      step <= 1;
      @(posedge clk);
      step <= 0;
      @(posedge clk);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {reset_n, psel, penable, pwrite, homing, step, p_act, m_act, o_act, s_act} = 0;
    {paddr, pwdata, din} = 0;
    ce = 1;
    ctrl = 8'h01;
    void'($urandom(46413));
    wt(2);
    reset_n <= 1;
    apb(0, `LSG_OFS_CTRL, 0);
    chk("ctrl", rd, 32'h1);
    apb(0, `LSG_OFS_GEAR_A, 0);
    chk("gear_a", rd, 32'h1);
    apb(0, 8'h24, 0);
    chk("slverr", er, 1);
    for (int m = 0; m < 2; m++)
    begin
      apb(1, `LSG_OFS_CTRL, 1 + 2 * m);
      p_act <= (m == 0);
      m_act <= (m == 1);
      wt(5);
      chk("stops", {stop_i, stop_d}, m == 0 ? 2 : 1);
      {p_act, m_act} <= 0;
      wt(4);
      apb(1, `LSG_OFS_COMMAND, 2);
      wt(1);
      chk("cleared", {stop_i, stop_d}, 0);
    end
    apb(1, `LSG_OFS_CTRL, 5);
    wt(5);
    chk("nc idle", {stop_i, stop_d}, 0);
    m_act <= 1;
    wt(5);
    chk("nc hit", stop_i, 1);
    apb(0, `LSG_OFS_STATUS, 0);
    chk("status", rd, 32'h22);
    m_act <= 0;
    wt(4);
    apb(1, `LSG_OFS_COMMAND, 2);
    apb(1, `LSG_OFS_CTRL, 4);
    p_act <= 1;
    wt(5);
    chk("ot off", {stop_i, stop_d}, 0);
    homing <= 1;
    apb(1, `LSG_OFS_CTRL, 8'h41);
    wt(5);
    chk("homing", {hp, hm, stop_i}, 4);
    p_act <= 0;
    for (int i = 0; i < 12; i++)
    begin
      v = 8'($urandom);
      v = (v & 8'h38) | ((i % 2) ? 8'h40 : (v & 8'hc0)) | 8'h01;
      o_act <= 1'($urandom);
      s_act <= 1'($urandom);
      apb(1, `LSG_OFS_CTRL, v);
      wt(5);
      chk("found", found, v[7:6] == 1 && o_act && (!v[5] || s_act));
    end
    {homing, o_act, s_act} <= 0;
    dir = 16'($urandom);
    inv = 16'($urandom);
    ni = 16'($urandom);
    din <= 16'($urandom);
    apb(1, `LSG_OFS_GP_DIR, dir);
    apb(1, `LSG_OFS_GP_INV, inv);
    apb(1, `LSG_OFS_NET_IN, ni);
    wt(4);
    chk("dout", dout, ni & dir);
    apb(0, `LSG_OFS_NET_OUT, 0);
    chk("net_out", rd[15:0] & ~dir, (din ^ inv) & ~dir);
    for (int i = 0; i < 6; i++)
    begin
      apb(1, `LSG_OFS_GEAR_A, ga[i]);
      apb(1, `LSG_OFS_GEAR_B, gb[i]);
      wt(1);
      chk("warn", warn, 1000 * gb[i] < 100 * ga[i] || 1000 * gb[i] > 10000 * ga[i]);
    end
    apb(1, `LSG_OFS_GEAR_A, 0);
    apb(0, `LSG_OFS_GEAR_A, 0);
    chk("gear zero", rd, 65535);
    apb(1, `LSG_OFS_GEAR_B, 1);
    apb(1, `LSG_OFS_COMMAND, 1);
    apb(1, `LSG_OFS_COMMAND, 4);
    chk("alarm", alarm, 1);
    apb(1, `LSG_OFS_GEAR_A, 50);
    apb(1, `LSG_OFS_GEAR_B, 50);
    homing <= 1;
    wt(2);
    homing <= 0;
    apb(1, `LSG_OFS_COMMAND, 4);
    wt(1);
    chk("alarm clr", alarm, 0);
    steps(19);
    wt(3);
    chk("pulses", pulses, 0);
    ce <= 0;
    steps(5);
    ce <= 1;
    chk("ce freeze", pulses, 0);
    steps(21);
    wt(3);
    chk("pulses", pulses, 2);
    final_report();
  end
endmodule
